// ===== pdwake_pkg.sv
// package: constants and carriers for the power-down / wake controller
// assumes: one clock domain, mclk_i at 125 MHz
package pdwake_pkg;
  localparam logic [7:0] OP_CLK_GATE = 8'h01;
  localparam logic [7:0] OP_OSC_STOP = 8'h82;
  localparam logic [7:0] OP_PORT_FLOAT = 8'hA2;
  localparam logic [7:0] OP_ALL_FLOAT = 8'hC2;
  localparam logic [7:0] OP_FLOAT_RELEASE = 8'hE2;
  localparam logic [1:0] WAKE_STROBES = 2'h2;
  localparam logic [2:0] VEC_RESET = 3'h0;
  localparam logic [2:0] VEC_EXT_IRQ = 3'h3;
  localparam logic [31:0] REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] REG_STATUS = 32'h0000_0004;
  localparam logic [31:0] REG_INSTR = 32'h0000_0008;
  localparam logic [31:0] REG_BUS_LATCH = 32'h0000_000C;
  localparam int CTRL_IRQ_EN = 0;
  localparam int CTRL_IN_ISR = 1;
  localparam int CTRL_EXT_ROM = 2;

  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_CLK_GATED = 4'h2,
    ST_OSC_STOPPED = 4'h4,
    ST_SOFT_WAIT = 4'h8
  } pd_state_t;

  typedef struct packed {
    logic core_clk_en;
    logic osc_en;
    logic cpu_hold;
    logic ss_pulldown;
    logic float_p1;
    logic [7:0] float_p2;
    logic float_bus;
    logic float_ctrl;
    logic float_strobes;
  } pin_ctl_t;

  typedef struct packed {
    pd_state_t st;
    logic irq_en;
    logic in_isr;
    logic ext_rom;
    logic port_flt;
    logic all_flt;
    logic hw_pd;
    logic [1:0] int_cnt;
    logic [1:0] rst_cnt;
    logic wake_is_rst;
    logic take_irq;
    logic take_rst;
    logic [7:0] bus_latch;
    logic [31:0] rdata;
    logic rvalid;
  } state_t;
endpackage : pdwake_pkg

// ===== power_down_wake_controller.sv
// power-down sequencer with avalon-mm register slave
// assumes: pins sampled on mclk_i; osc_running_i reports oscillator output;
// ale_pulse_i is one cycle per address-latch strobe
// Function
// - clock-gate op keeps osc, stops cpu clock
// - clock-gate exit resumes without osc wait
// - osc-stop op halts oscillator and cpu
// - osc-stop exit waits for soft-start pin, except after a reset wake
// - port-float op floats ports per rom mode
// - all-float op floats all outputs per mode
// - float persists through following clock stop
// - irq enabled int low wakes, vectors 3
// - wake inside isr resumes next instruction
// - irq disabled int low resumes next instruction
// - reset low wakes, resets to address 0
// - power-down pin low stops osc, floats io
// - pin rise with reset low resets
// - pin rise with int low vectors 3
// - hardware pd in isr resumes next
// - pin rise, int low, irq off resumes
// - pin rise, pins high resumes in place
// - soft-start pulldown while osc stopped
// - bus latch separate from address latch
// - release op, int low, reset low unfloat
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
module power_down_wake_controller (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [31:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [7:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic int_n_i,
  input wire logic reset_pin_n_i,
  input wire logic pd_pin_n_i,
  input wire logic ss_pin_high_i,
  input wire logic osc_running_i,
  input wire logic ale_pulse_i,
  input wire logic [7:0] rom_addr_i,
  input wire logic rom_addr_load_i,
  output pdwake_pkg::pin_ctl_t pin_ctl_o,
  output logic [7:0] bus_port_o,
  output logic cpu_irq_o,
  output logic cpu_reset_o,
  output logic [2:0] cpu_vector_o,
  output logic power_state_output
);
  pdwake_pkg::state_t s_q;
  pdwake_pkg::state_t s_d;
  logic int_async_n;
  logic rst_async_n;
  logic wake_any;
  logic [7:0] rom_addr_q;
  logic stopped;
  logic flt_any;
  logic [7:0] flt_p2;

  // level detection is purely combinational: no clock edge needed
  assign int_async_n = int_n_i;
  assign rst_async_n = reset_pin_n_i;
  assign stopped = s_q.st != pdwake_pkg::ST_RUN;
  assign wake_any = !int_async_n || !rst_async_n;

  always_comb begin
    s_d = s_q;
    s_d.take_irq = 1'b0;
    s_d.take_rst = 1'b0;
    s_d.rvalid = 1'b0;
    if (instr_valid_i && s_q.st == pdwake_pkg::ST_RUN && !s_q.hw_pd) begin
      case (instr_i)
        pdwake_pkg::OP_CLK_GATE: s_d.st = pdwake_pkg::ST_CLK_GATED;
        pdwake_pkg::OP_OSC_STOP: s_d.st = pdwake_pkg::ST_OSC_STOPPED;
        pdwake_pkg::OP_PORT_FLOAT: s_d.port_flt = 1'b1;
        pdwake_pkg::OP_ALL_FLOAT: s_d.all_flt = 1'b1;
        pdwake_pkg::OP_FLOAT_RELEASE: begin
          s_d.port_flt = 1'b0;
          s_d.all_flt = 1'b0;
        end
        default: ;
      endcase
    end
    if (!pd_pin_n_i) begin
      s_d.hw_pd = 1'b1;
      s_d.st = pdwake_pkg::ST_OSC_STOPPED;
    end
    // floats persist across clock stop, cleared by wake levels or the release op
    if (wake_any) begin
      s_d.port_flt = 1'b0;
      s_d.all_flt = 1'b0;
    end
    case (s_q.st)
      pdwake_pkg::ST_RUN: ;
      pdwake_pkg::ST_CLK_GATED: begin
        if (wake_any) begin
          s_d.st = pdwake_pkg::ST_RUN;
          s_d.wake_is_rst = !rst_async_n;
        end
      end
      pdwake_pkg::ST_OSC_STOPPED: begin
        if (pd_pin_n_i && (wake_any || s_q.hw_pd)) begin
          s_d.hw_pd = 1'b0;
          s_d.wake_is_rst = !rst_async_n;
          s_d.st = pdwake_pkg::ST_SOFT_WAIT;
        end
      end
      pdwake_pkg::ST_SOFT_WAIT: begin
        // reset wake skips the soft-start pin but still waits for osc_running_i
        if (osc_running_i && (ss_pin_high_i || s_q.wake_is_rst)) begin
          s_d.st = pdwake_pkg::ST_RUN;
        end
      end
      default: s_d.st = pdwake_pkg::ST_RUN;
    endcase
    // count strobes while each wake level stays low
    if (!int_async_n) begin
      if (ale_pulse_i && s_q.int_cnt != pdwake_pkg::WAKE_STROBES) begin
        s_d.int_cnt = s_q.int_cnt + 2'h1;
      end
    end else begin
      s_d.int_cnt = 2'h0;
    end
    if (!rst_async_n) begin
      if (ale_pulse_i && s_q.rst_cnt != pdwake_pkg::WAKE_STROBES) begin
        s_d.rst_cnt = s_q.rst_cnt + 2'h1;
      end
    end else begin
      s_d.rst_cnt = 2'h0;
    end
    if (s_d.rst_cnt == pdwake_pkg::WAKE_STROBES && s_q.rst_cnt != pdwake_pkg::WAKE_STROBES) begin
      s_d.take_rst = 1'b1;
      s_d.irq_en = 1'b0;
      s_d.in_isr = 1'b0;
    end else if (s_d.int_cnt == pdwake_pkg::WAKE_STROBES && s_q.int_cnt != pdwake_pkg::WAKE_STROBES) begin
      // disabled or in-isr: resume at next instruction, no vector
      s_d.take_irq = s_q.irq_en && !s_q.in_isr;
    end
    if (avs_write_i) begin
      if (avs_address_i == pdwake_pkg::REG_CTRL && avs_byteenable_i[0]) begin
        s_d.irq_en = avs_writedata_i[pdwake_pkg::CTRL_IRQ_EN];
        s_d.in_isr = avs_writedata_i[pdwake_pkg::CTRL_IN_ISR];
        s_d.ext_rom = avs_writedata_i[pdwake_pkg::CTRL_EXT_ROM];
      end
      if (avs_address_i == pdwake_pkg::REG_BUS_LATCH && avs_byteenable_i[0]) begin
        s_d.bus_latch = avs_writedata_i[7:0];
      end
    end
    // one wait state per read, so a back-to-back read fetches afresh
    if (avs_read_i && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      case (avs_address_i)
        pdwake_pkg::REG_CTRL: s_d.rdata = {29'h0, s_q.ext_rom, s_q.in_isr, s_q.irq_en};
        pdwake_pkg::REG_STATUS: s_d.rdata = {24'h0, s_q.hw_pd, s_q.all_flt, s_q.port_flt, 1'b0, s_q.st};
        pdwake_pkg::REG_BUS_LATCH: s_d.rdata = {24'h0, s_q.bus_latch};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '{st: pdwake_pkg::ST_RUN, default: '0};
      rom_addr_q <= 8'h00;
    end else begin
      s_q <= s_d;
      if (rom_addr_load_i) begin
        rom_addr_q <= rom_addr_i;
      end
    end
  end

  assign avs_waitrequest_o = avs_read_i && !s_q.rvalid;
  assign avs_readdata_o = s_q.rdata;

  assign flt_any = s_q.port_flt || s_q.all_flt;

  // upper port two nibble floats in both modes, lower nibble only with internal rom or under the power-down pin
  for (genvar b = 0; b < 8; b = b + 1) begin : g_p2_float
    if (b >= 4) begin : g_hi
      assign flt_p2[b] = flt_any || s_q.hw_pd;
    end else begin : g_lo
      assign flt_p2[b] = (flt_any && !s_q.ext_rom) || s_q.hw_pd;
    end
  end

  always_comb begin
    pin_ctl_o.core_clk_en = s_q.st == pdwake_pkg::ST_RUN;
    pin_ctl_o.osc_en = !(s_q.st == pdwake_pkg::ST_OSC_STOPPED);
    pin_ctl_o.cpu_hold = stopped;
    pin_ctl_o.ss_pulldown = s_q.st == pdwake_pkg::ST_OSC_STOPPED;
    pin_ctl_o.float_p1 = flt_any || s_q.hw_pd;
    pin_ctl_o.float_p2 = flt_p2;
    pin_ctl_o.float_bus = (flt_any && !s_q.ext_rom) || s_q.hw_pd;
    pin_ctl_o.float_ctrl = s_q.all_flt || s_q.hw_pd;
    pin_ctl_o.float_strobes = (s_q.all_flt && !s_q.ext_rom) || s_q.hw_pd;
  end

  assign bus_port_o = s_q.ext_rom ? rom_addr_q : s_q.bus_latch;
  assign cpu_irq_o = s_q.take_irq;
  assign cpu_reset_o = s_q.take_rst;
  assign cpu_vector_o = s_q.take_rst ? pdwake_pkg::VEC_RESET : pdwake_pkg::VEC_EXT_IRQ;
  assign power_state_output = stopped;
endmodule : power_down_wake_controller

// ===== pdwake_monitor.sv
// checker for the power-down wake controller pins
// assumes one clock domain, bound to the controller
`timescale 1ns/10ps
module pdwake_monitor (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [7:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic pd_pin_n_i,
  input wire logic int_n_i,
  input wire logic reset_pin_n_i,
  input wire pdwake_pkg::pin_ctl_t pin_ctl_o,
  input wire logic cpu_irq_o,
  input wire logic cpu_reset_o,
  input wire logic [2:0] cpu_vector_o,
  input wire logic power_state_output
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  logic go_gate, go_stop, go_rel;
  logic gated_q;
  // a low power-down pin overrides a gate or release instruction taken in the same cycle
  assign go_gate = instr_valid_i && pd_pin_n_i && !power_state_output && instr_i == pdwake_pkg::OP_CLK_GATE;
  assign go_stop = instr_valid_i && !power_state_output && instr_i == pdwake_pkg::OP_OSC_STOP;
  assign go_rel = instr_valid_i && pd_pin_n_i && !power_state_output && instr_i == pdwake_pkg::OP_FLOAT_RELEASE;
  // high while the clock-gated state entered by the gate op lasts
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gated_q <= 1'b0;
    end else begin
      gated_q <= go_gate || (gated_q && !pin_ctl_o.core_clk_en && pin_ctl_o.osc_en && pd_pin_n_i);
    end
  end
  a_gate_wake: assert property (gated_q && !pin_ctl_o.core_clk_en && pd_pin_n_i && !int_n_i |=> pin_ctl_o.core_clk_en)
    else $error("gated wake waited");
  a_gate_osc: assert property (go_gate |=> pin_ctl_o.osc_en && !pin_ctl_o.core_clk_en)
    else $error("gate lost osc");
  a_stop_osc: assert property (go_stop |=> !pin_ctl_o.osc_en && power_state_output)
    else $error("osc not stopped");
  a_float_held: assert property (go_stop && pin_ctl_o.float_p1 |=> pin_ctl_o.float_p1)
    else $error("float lost");
  a_release_float: assert property (go_rel |=> !pin_ctl_o.float_p1)
    else $error("float kept");
  a_ss_pulldown: assert property (!pin_ctl_o.osc_en |-> pin_ctl_o.ss_pulldown)
    else $error("no pulldown");
  a_hw_pd_stop: assert property (!pd_pin_n_i [*4] |-> !pin_ctl_o.osc_en && pin_ctl_o.float_p1)
    else $error("pd pin ignored");
  a_irq_vector: assert property (cpu_irq_o |-> cpu_vector_o == pdwake_pkg::VEC_EXT_IRQ && !cpu_reset_o)
    else $error("bad irq vector");
  a_reset_vector: assert property (cpu_reset_o |-> cpu_vector_o == pdwake_pkg::VEC_RESET)
    else $error("bad reset vector");
  c_irq: cover property (cpu_irq_o);
  c_rst: cover property (cpu_reset_o);
  c_stop: cover property (go_stop);
  c_gate_wake: cover property (gated_q && !int_n_i && reset_pin_n_i);
endmodule : pdwake_monitor
bind power_down_wake_controller pdwake_monitor i_pdwake_monitor (.*);

// ===== pdwake_partner.sv
// far side: oscillator start-up, strobe and soft-start pin
// assumes enables come from the controller pin controls
`timescale 1ns/10ps
module pdwake_partner (
  input wire logic mclk_i,
  input wire logic osc_en_i,
  input wire logic ss_pulldown_i,
  input wire logic float_bus_i,
  input wire logic [7:0] bus_port_i,
  output logic osc_running_o,
  output logic ss_pin_high_o,
  output logic ale_pulse_o,
  output logic [7:0] bus_pin_o
);
  logic [2:0] osc_cnt_q = 3'h4;
  logic [1:0] ale_cnt_q = 2'h0;
  always @(posedge mclk_i) begin
    osc_cnt_q <= !osc_en_i ? 3'h0 : (osc_cnt_q[2] ? osc_cnt_q : osc_cnt_q + 3'h1);
    ale_cnt_q <= ale_cnt_q + 2'h1;
  end
  assign osc_running_o = osc_cnt_q[2];
  // capacitor charges only once pulled up and oscillating
  assign ss_pin_high_o = osc_running_o && !ss_pulldown_i;
  assign ale_pulse_o = osc_running_o && (ale_cnt_q == 2'h3);
  // board pull-ups fix the level of a floated bus port
  assign bus_pin_o = float_bus_i ? 8'hFF : bus_port_i;
endmodule : pdwake_partner

// ===== power_down_wake_controller_bench.sv
// bench for the power-down wake controller
// assumes partner model drives oscillator, strobe and soft-start
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin n_errors++; $display("mismatch %s exp %h got %h", n, e, a); end end
module power_down_wake_controller_bench;
  logic mclk_i = 1'b0, resetn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0, instr_valid_i = 1'b0;
  logic int_n_i = 1'b1, reset_pin_n_i = 1'b1, pd_pin_n_i = 1'b1, rom_addr_load_i = 1'b0;
  logic [31:0] avs_address_i = 32'h0, avs_writedata_i = 32'h0, avs_readdata_o, d;
  logic [7:0] instr_i = 8'h00, rom_addr_i = 8'h3C, bus_port_o, bus_pin;
  logic [3:0] avs_byteenable_i = 4'h1;
  logic avs_waitrequest_o, ss_pin_high_i, osc_running_i, ale_pulse_i, cpu_irq_o, cpu_reset_o, power_state_output;
  logic [2:0] cpu_vector_o;
  pdwake_pkg::pin_ctl_t pin_ctl_o;
  int n_errors = 0, samples_checked = 0, cycles = 0, n_irq = 0, n_rst = 0;
  power_down_wake_controller i_power_down_wake_controller (.*);
  pdwake_partner i_pdwake_partner (.mclk_i(mclk_i), .osc_en_i(pin_ctl_o.osc_en), .ss_pulldown_i(pin_ctl_o.ss_pulldown),
    .float_bus_i(pin_ctl_o.float_bus), .bus_port_i(bus_port_o), .osc_running_o(osc_running_i),
    .ss_pin_high_o(ss_pin_high_i), .ale_pulse_o(ale_pulse_i), .bus_pin_o(bus_pin));
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    n_irq <= n_irq + int'(cpu_irq_o);
    n_rst <= n_rst + int'(cpu_reset_o);
    if (cycles == 4000) begin
      n_errors++;
      stop_test();
    end
  end
  task stop_test();
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task bus(input logic w, input logic [31:0] a, input logic [31:0] v);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= v;
    @(posedge mclk_i);
    while (avs_waitrequest_o) @(posedge mclk_i);
    d = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge mclk_i);
  endtask : bus
  task op(input logic [7:0] c);
    instr_i <= c;
    instr_valid_i <= 1'b1;
    @(posedge mclk_i);
    instr_valid_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask : op
  // pull {pd, reset, int} low, raise pd, hold the rest until 12 cycles past running
  task wake(input logic [2:0] m);
    {pd_pin_n_i, reset_pin_n_i, int_n_i} <= ~m;
    repeat (8) @(posedge mclk_i);
    pd_pin_n_i <= 1'b1;
    @(posedge mclk_i);
    while (power_state_output) @(posedge mclk_i);
    repeat (12) @(posedge mclk_i);
    {pd_pin_n_i, reset_pin_n_i, int_n_i} <= 3'h7;
    repeat (2) @(posedge mclk_i);
  endtask : wake
  initial begin
    repeat (5) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    bus(1'b1, pdwake_pkg::REG_CTRL, 32'h4);
    bus(1'b0, pdwake_pkg::REG_CTRL, 32'h0);
    `CHK("ctrl", 32'h4, d)
    bus(1'b0, 32'h10, 32'h0);
    `CHK("unmapped", 32'h0, d)
    bus(1'b1, pdwake_pkg::REG_BUS_LATCH, 32'h5A);
    rom_addr_load_i <= 1'b1;
    op(pdwake_pkg::OP_PORT_FLOAT);
    rom_addr_load_i <= 1'b0;
    `CHK("ext addr", 8'h3C, bus_port_o)
    `CHK("ext flt", 10'h3E0, {pin_ctl_o.float_p1, pin_ctl_o.float_p2, pin_ctl_o.float_bus})
    op(pdwake_pkg::OP_ALL_FLOAT);
    `CHK("ext all", 2'h2, {pin_ctl_o.float_ctrl, pin_ctl_o.float_strobes})
    op(pdwake_pkg::OP_FLOAT_RELEASE);
    bus(1'b1, pdwake_pkg::REG_CTRL, 32'h0);
    `CHK("latch", 8'h5A, bus_port_o)
    `CHK("bus pin", 8'h5A, bus_pin)
    op(pdwake_pkg::OP_ALL_FLOAT);
    op(pdwake_pkg::OP_OSC_STOP);
    `CHK("stopped", 3'h3, {pin_ctl_o.osc_en, pin_ctl_o.ss_pulldown, pin_ctl_o.float_strobes})
    `CHK("held", 2'h3, {pin_ctl_o.cpu_hold, power_state_output})
    `CHK("pulled bus", 8'hFF, bus_pin)
    bus(1'b0, pdwake_pkg::REG_STATUS, 32'h0);
    `CHK("status", 32'h44, d)
    wake(3'h1);
    `CHK("int wake", 2'h0, {pin_ctl_o.float_p1, n_irq[0]})
    bus(1'b1, pdwake_pkg::REG_CTRL, 32'h1);
    op(pdwake_pkg::OP_CLK_GATE);
    `CHK("gated", 2'h2, {pin_ctl_o.osc_en, pin_ctl_o.core_clk_en})
    wake(3'h1);
    `CHK("irq", 1, n_irq)
    bus(1'b1, pdwake_pkg::REG_CTRL, 32'h3);
    op(pdwake_pkg::OP_OSC_STOP);
    wake(3'h1);
    `CHK("isr", 1, n_irq)
    op(pdwake_pkg::OP_OSC_STOP);
    wake(3'h2);
    `CHK("rst wake", 1, n_rst)
    bus(1'b0, pdwake_pkg::REG_CTRL, 32'h0);
    `CHK("rst ctrl", 32'h0, d)
    wake(3'h4);
    `CHK("hw resume", 2, n_irq + n_rst)
    bus(1'b1, pdwake_pkg::REG_CTRL, 32'h1);
    wake(3'h5);
    `CHK("hw irq", 2, n_irq)
    wake(3'h6);
    `CHK("hw rst", 2, n_rst)
    wake(3'h5);
    `CHK("hw irq off", 2, n_irq)
    bus(1'b1, pdwake_pkg::REG_CTRL, 32'h3);
    wake(3'h5);
    `CHK("hw isr", 2, n_irq)
    stop_test();
  end
endmodule : power_down_wake_controller_bench
